// >>> hw/cag_pkg.sv
/*
 * constants and types shared by the address-generation block of the core.
 * assumes one core clock and a synchronous active-high reset.
 */
// Contract
// - outside branches, instruction pointer advances one per fetched byte
// - relative branch target is next-instruction address plus 8-bit offset
// - relative offset is signed, bit 7 sign-extended, reach -128..+127
// - short unconditional jump and all conditional branches use relative form
// - absolute call and jump load the full 16-bit immediate target
// - register jump loads instruction pointer from accumulator pair
// - direct operand uses a 16-bit immediate address
// - peripheral addressing puts 8-bit immediate at low byte of FF00H..FFFFH
// - registers FF00H..FF1FH also reachable with short direct form
// - 16-bit peripheral access allowed only with short direct form
// - wide registers also accept byte access under direct addressing
// - with 8-bit converter the result is a byte register at FF15H
// - with 10-bit converter the result is reachable only as 16 bits
// - 8-bit register operand chosen by 3-bit field among eight registers
// - register-indirect uses index pair or base pair over whole space
// - based address is base pair plus zero-extended offset, carry dropped
// - stack pointer addresses push, pop, call, return and interrupt save; the code uses it for push and pop only
// - stack accesses confined to internal high-speed RAM
// - byte registers numbered R0..R7, pairs RP0..RP3, forming select code
package cag_pkg;
    // ------------------------------------------------------------
    // addresses and regions
    // ------------------------------------------------------------
    localparam logic [15:0] CAG_PC_RESET = 16'h0000;
    localparam logic [15:0] CAG_SP_RESET = 16'hfeff;
    localparam logic [15:0] CAG_PERIPH_BASE = 16'hff00;
    localparam logic [15:0] CAG_SHORT_LAST = 16'hff1f;
    localparam logic [15:0] CAG_TABLE_BASE = 16'h0040;
    localparam logic [15:0] CAG_RAM_FIRST = 16'hfd00;
    localparam logic [15:0] CAG_RAM_LAST = 16'hfeff;
    localparam logic [7:0] CAG_PRODUCT_LO = 8'h10;
    localparam logic [7:0] CAG_CONV_LO = 8'h14;
    localparam logic [7:0] CAG_CONV_BYTE = 8'h15;
    localparam logic [7:0] CAG_COMPARE_LO = 8'h16;
    localparam logic [7:0] CAG_COUNTER_LO = 8'h18;
    localparam logic [7:0] CAG_CAPTURE_LO = 8'h1a;
    localparam logic [2:0] CAG_ACC_PAIR = 3'h0;
    localparam logic [2:0] CAG_INDEX_PAIR = 3'h2;
    localparam logic [2:0] CAG_BASE_PAIR = 3'h3;
    // ------------------------------------------------------------
    // branch kinds and operand modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CAG_BR_NONE = 3'b000,
        CAG_BR_REL = 3'b001,
        CAG_BR_COND = 3'b010,
        CAG_BR_ABS = 3'b011,
        CAG_BR_TABLE = 3'b100,
        CAG_BR_REG = 3'b101
    } cag_branch_t;
    typedef enum logic [2:0] {
        CAG_OP_NONE = 3'b000,
        CAG_OP_DIRECT = 3'b001,
        CAG_OP_PERIPH = 3'b010,
        CAG_OP_SHORT = 3'b011,
        CAG_OP_INDIRECT = 3'b100,
        CAG_OP_BASED = 3'b101,
        CAG_OP_PUSH = 3'b110,
        CAG_OP_POP = 3'b111
    } cag_mode_t;
    typedef enum logic [1:0] {
        CAG_TB_IDLE = 2'b00,
        CAG_TB_LOW = 2'b01,
        CAG_TB_HIGH = 2'b10
    } cag_tstate_t;
endpackage

// >>> hw/cag_addr_gen.sv
/*
 * address generation for the core: branch targets into the instruction
 * pointer, operand addresses, register selects and peripheral width checks.
 * assumes the decoder holds its request for one cycle and that the table
 * read returns data on mem_rdata in the cycle in which mem_req stands.
 */
`timescale 1ns/1ns
module cag_addr_gen
    import cag_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic step,
    input wire logic [1:0] fetch_len,
    input wire cag_branch_t branch_kind,
    input wire logic cond_true,
    input wire logic [7:0] relative_offset,
    input wire logic [15:0] imm16,
    input wire logic [7:0] opcode,
    input wire logic [15:0] accumulator_pair,
    input wire logic [15:0] index_pair,
    input wire logic [15:0] base_pair,
    input wire cag_mode_t op_mode,
    input wire logic [7:0] imm8,
    input wire logic op_wide,
    input wire logic op_write,
    input wire logic use_index,
    input wire logic [2:0] reg_field,
    input wire logic conv_10bit,
    input wire logic [7:0] mem_rdata,
    output logic [15:0] instruction_pointer,
    output logic [15:0] stack_pointer,
    output logic [15:0] mem_addr,
    output logic mem_req,
    output logic mem_we,
    output logic mem_wide,
    output logic access_fault,
    output logic periph_drop,
    output logic [7:0] reg_select,
    output logic table_busy
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] ip_q, ip_d, sp_q, sp_d, addr_q, addr_d;
    logic req_q, req_d, we_q, we_d, wide_q, wide_d, fault_q, fault_d, drop_q, drop_d, busy_q, busy_d;
    logic [7:0] sel_q, sel_d, tlo_q, tlo_d;
    cag_tstate_t ts_q, ts_d;
    logic [15:0] next_ip, ea;
    logic in_periph, in_short, is_wide_reg, is_conv, bad_width;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        ip_d = ip_q;
        sp_d = sp_q;
        ts_d = ts_q;
        tlo_d = tlo_q;
        addr_d = addr_q;
        req_d = 1'b0;
        we_d = 1'b0;
        wide_d = 1'b0;
        fault_d = 1'b0;
        drop_d = 1'b0;
        sel_d = 8'h00;
        ea = 16'h0000;
        next_ip = ip_q + {14'h0000, fetch_len};
        bad_width = 1'b0;
        // operand effective address per mode
        case (op_mode)
            CAG_OP_DIRECT: ea = imm16;
            CAG_OP_PERIPH: ea = {CAG_PERIPH_BASE[15:8], imm8};
            CAG_OP_SHORT: ea = {CAG_PERIPH_BASE[15:8], 3'b000, imm8[4:0]};
            CAG_OP_INDIRECT: ea = use_index ? index_pair : base_pair;
            CAG_OP_BASED: ea = base_pair + {8'h00, imm8};
            CAG_OP_PUSH: ea = sp_q - (op_wide ? 16'h0002 : 16'h0001);
            CAG_OP_POP: ea = sp_q;
            default: ea = 16'h0000;
        endcase
        in_periph = (ea >= CAG_PERIPH_BASE);
        in_short = (ea <= CAG_SHORT_LAST) && in_periph;
        is_wide_reg = in_periph && (ea[7:1] == CAG_PRODUCT_LO[7:1] || ea[7:1] == CAG_COMPARE_LO[7:1]
            || ea[7:1] == CAG_COUNTER_LO[7:1] || ea[7:1] == CAG_CAPTURE_LO[7:1]);
        is_conv = in_periph && (ea[7:1] == CAG_CONV_LO[7:1]);
        // width checks on the peripheral area
        if (op_mode != CAG_OP_NONE && in_periph) begin
            if (op_wide && (op_mode != CAG_OP_SHORT || !in_short)) begin
                bad_width = 1'b1;
            end else if (op_wide && ea[0]) begin
                bad_width = 1'b1;
            end else if (!op_wide && is_wide_reg && op_mode != CAG_OP_DIRECT) begin
                bad_width = 1'b1;
            end else if (is_conv && conv_10bit && !op_wide) begin
                bad_width = 1'b1;
            end else if (is_conv && !conv_10bit && (op_wide || ea[7:0] != CAG_CONV_BYTE)) begin
                bad_width = 1'b1;
            end
        end
        if ((op_mode == CAG_OP_PUSH || op_mode == CAG_OP_POP)
            && (ea < CAG_RAM_FIRST || ea > CAG_RAM_LAST)) begin
            bad_width = 1'b1;
        end
        // issue operand access
        if (step && op_mode != CAG_OP_NONE && ts_q == CAG_TB_IDLE) begin
            addr_d = ea;
            wide_d = op_wide;
            if (bad_width) begin
                fault_d = 1'b1;
                drop_d = op_write && in_periph;
            end else begin
                req_d = 1'b1;
                we_d = op_write;
                if (op_mode == CAG_OP_PUSH) begin
                    sp_d = ea;
                end else if (op_mode == CAG_OP_POP) begin
                    sp_d = sp_q + (op_wide ? 16'h0002 : 16'h0001);
                end
            end
        end
        // register select one-hot
        if (step) begin
            sel_d[reg_field] = 1'b1;
        end
        // instruction pointer update
        case (ts_q)
            CAG_TB_IDLE: begin
                if (step) begin
                    case (branch_kind)
                        CAG_BR_REL: ip_d = next_ip + {{8{relative_offset[7]}}, relative_offset};
                        CAG_BR_COND: ip_d = cond_true ? next_ip + {{8{relative_offset[7]}}, relative_offset}
                            : next_ip;
                        CAG_BR_ABS: ip_d = imm16;
                        CAG_BR_REG: ip_d = accumulator_pair;
                        CAG_BR_TABLE: begin
                            addr_d = CAG_TABLE_BASE + {10'h000, opcode[5:1], 1'b0};
                            req_d = 1'b1;
                            we_d = 1'b0;
                            wide_d = 1'b0;
                            ts_d = CAG_TB_LOW;
                        end
                        default: ip_d = next_ip;
                    endcase
                end
            end
            CAG_TB_LOW: begin
                tlo_d = mem_rdata;
                addr_d = addr_q + 16'h0001;
                req_d = 1'b1;
                ts_d = CAG_TB_HIGH;
            end
            CAG_TB_HIGH: begin
                ip_d = {mem_rdata, tlo_q};
                ts_d = CAG_TB_IDLE;
            end
            default: ts_d = CAG_TB_IDLE;
        endcase
        // busy flag kept in a flop so table_busy is registered
        busy_d = (ts_d != CAG_TB_IDLE);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            ip_q <= CAG_PC_RESET;
            sp_q <= CAG_SP_RESET;
            addr_q <= 16'h0000;
            req_q <= 1'b0;
            we_q <= 1'b0;
            wide_q <= 1'b0;
            fault_q <= 1'b0;
            drop_q <= 1'b0;
            sel_q <= 8'h00;
            tlo_q <= 8'h00;
            ts_q <= CAG_TB_IDLE;
            busy_q <= 1'b0;
        end else begin
            ip_q <= ip_d;
            sp_q <= sp_d;
            addr_q <= addr_d;
            req_q <= req_d;
            we_q <= we_d;
            wide_q <= wide_d;
            fault_q <= fault_d;
            drop_q <= drop_d;
            sel_q <= sel_d;
            tlo_q <= tlo_d;
            ts_q <= ts_d;
            busy_q <= busy_d;
        end
    end

    assign instruction_pointer = ip_q;
    assign stack_pointer = sp_q;
    assign mem_addr = addr_q;
    assign mem_req = req_q;
    assign mem_we = we_q;
    assign mem_wide = wide_q;
    assign access_fault = fault_q;
    assign periph_drop = drop_q;
    assign reg_select = sel_q;
    assign table_busy = busy_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    step_advance_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_NONE
        |=> ip_q == $past(ip_q) + {14'h0000, $past(fetch_len)})
        else $error("pointer did not advance by fetch length");
    rel_target_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_REL
        |=> ip_q == $past(next_ip) + {{8{$past(relative_offset[7])}}, $past(relative_offset)})
        else $error("relative target wrong");
    abs_target_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_ABS |=> ip_q == $past(imm16))
        else $error("absolute target wrong");
    reg_jump_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_REG |=> ip_q == $past(accumulator_pair))
        else $error("register jump wrong");
    table_seq_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_TABLE
        |=> mem_req && mem_addr[15:6] == 10'h001 ##1 mem_req ##1 !table_busy)
        else $error("table call sequence wrong");
    wide_short_a: assert property (@(posedge clk) disable iff (rst)
        mem_req && mem_wide && mem_addr[15:8] == 8'hff |-> mem_addr <= CAG_SHORT_LAST)
        else $error("wide peripheral access outside short area");
    based_addr_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_BASED && !bad_width
        |=> mem_addr == $past(base_pair) + {8'h00, $past(imm8)})
        else $error("based address wrong");
    stack_ram_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && (op_mode == CAG_OP_PUSH || op_mode == CAG_OP_POP)
        |=> access_fault || (mem_addr >= CAG_RAM_FIRST && mem_addr <= CAG_RAM_LAST))
        else $error("stack access left ram");

    // ------------------------------------------------------------
    // checks: conditional and table branches
    // ------------------------------------------------------------
    // conditional branch takes the offset only when the condition holds
    cond_branch_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && branch_kind == CAG_BR_COND
        |=> ip_q == ($past(cond_true)
            ? $past(next_ip) + {{8{$past(relative_offset[7])}}, $past(relative_offset)}
            : $past(next_ip)))
        else $error("conditional target wrong");
    // second table read is the odd byte after the even one
    table_pair_a: assert property (@(posedge clk) disable iff (rst)
        ts_q == CAG_TB_LOW |=> mem_req && !mem_we && mem_addr == $past(mem_addr) + 16'h0001)
        else $error("table high byte address wrong");

    // ------------------------------------------------------------
    // checks: operand addresses
    // ------------------------------------------------------------
    // direct form uses the full immediate address
    direct_addr_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_DIRECT && !bad_width
        |=> mem_req && mem_addr == $past(imm16))
        else $error("direct address wrong");
    // peripheral form puts the immediate in the top page
    periph_addr_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_PERIPH
        |=> mem_addr == {CAG_PERIPH_BASE[15:8], $past(imm8)})
        else $error("peripheral address wrong");
    // short form stays inside its window
    short_addr_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_SHORT
        |=> mem_addr >= CAG_PERIPH_BASE && mem_addr <= CAG_SHORT_LAST)
        else $error("short address outside window");
    // indirect form picks the named pair
    indirect_addr_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_INDIRECT
        |=> mem_addr == ($past(use_index) ? $past(index_pair) : $past(base_pair)))
        else $error("indirect address wrong");
    // exactly the named register is selected
    reg_select_a: assert property (@(posedge clk) disable iff (rst)
        step |=> reg_select == (8'h01 << $past(reg_field)))
        else $error("register select wrong");

    // ------------------------------------------------------------
    // checks: peripheral widths, refusals and stack
    // ------------------------------------------------------------
    // a refused access never reaches the bus
    fault_quiet_a: assert property (@(posedge clk) disable iff (rst)
        access_fault |-> !mem_req && !mem_we)
        else $error("refused access reached the bus");
    // byte access to a wide register only through the direct form
    wide_byte_a: assert property (@(posedge clk) disable iff (rst)
        mem_req && !mem_wide && mem_addr[15:8] == CAG_PERIPH_BASE[15:8]
        && (mem_addr[7:1] == CAG_PRODUCT_LO[7:1] || mem_addr[7:1] == CAG_COMPARE_LO[7:1]
        || mem_addr[7:1] == CAG_COUNTER_LO[7:1] || mem_addr[7:1] == CAG_CAPTURE_LO[7:1])
        |-> $past(op_mode) == CAG_OP_DIRECT)
        else $error("wide register byte access outside direct form");
    // ten-bit converter result only as a whole word
    conv_word_a: assert property (@(posedge clk) disable iff (rst)
        mem_req && $past(conv_10bit) && mem_addr[15:1] == {CAG_PERIPH_BASE[15:8], CAG_CONV_LO[7:1]}
        |-> mem_wide)
        else $error("ten-bit result read as a byte");
    // eight-bit converter result only as its own byte
    conv_byte_a: assert property (@(posedge clk) disable iff (rst)
        mem_req && !$past(conv_10bit) && mem_addr[15:1] == {CAG_PERIPH_BASE[15:8], CAG_CONV_LO[7:1]}
        |-> !mem_wide && mem_addr[7:0] == CAG_CONV_BYTE)
        else $error("eight-bit result not its byte");
    // a dropped write is a refused peripheral write
    drop_refused_a: assert property (@(posedge clk) disable iff (rst)
        periph_drop |-> access_fault && mem_addr >= CAG_PERIPH_BASE)
        else $error("dropped write not a refused peripheral write");
    // push lowers the pointer by the access width
    push_sp_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_PUSH && !bad_width
        |=> stack_pointer == $past(sp_q) - ($past(op_wide) ? 16'h0002 : 16'h0001))
        else $error("push pointer wrong");
    // pop raises the pointer by the access width
    pop_sp_a: assert property (@(posedge clk) disable iff (rst)
        step && ts_q == CAG_TB_IDLE && op_mode == CAG_OP_POP && !bad_width
        |=> stack_pointer == $past(sp_q) + ($past(op_wide) ? 16'h0002 : 16'h0001))
        else $error("pop pointer wrong");
    // a refused access leaves the stack pointer alone
    stack_hold_a: assert property (@(posedge clk) disable iff (rst)
        access_fault |-> $stable(stack_pointer))
        else $error("refused access moved stack pointer");
endmodule // cag_addr_gen

// >>> verification/cag_mem_model.sv
/*
 * memory-side partner: answers table reads in the cycle mem_req stands.
 * assumes table byte at any address is its low address byte xor a5.
 */
`timescale 1ns/1ns
module cag_mem_model
    import cag_pkg::*;
(
    input wire logic clk,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    output logic [7:0] mem_rdata
);
    logic [7:0] churn_q = 8'h3c;
    // idle bus churns every cycle so an early or late sample reads garbage
    always @(posedge clk) begin
        churn_q <= ~churn_q;
    end
    // read data stands in the cycle in which mem_req is held
    assign mem_rdata = mem_req ? (mem_addr[7:0] ^ 8'ha5) : churn_q;
endmodule // cag_mem_model

// >>> verification/test_cpu_address_generation.sv
/*
 * self-checking bench for cag_addr_gen with the memory partner.
 * assumes a 100 MHz clock and inputs driven at the falling edge.
 */
`timescale 1ns/1ns
module test_cpu_address_generation
    import cag_pkg::*;
;
    logic clk = 0, rst = 1, step = 0, cond_true = 0, op_wide = 0, op_write = 0;
    logic use_index = 0, conv_10bit = 0, mem_req, mem_we, mem_wide;
    logic access_fault, periph_drop, table_busy;
    logic [1:0] fetch_len = 2'h1;
    cag_branch_t branch_kind = CAG_BR_NONE;
    cag_mode_t op_mode = CAG_OP_NONE;
    logic [7:0] relative_offset = 8'h00, opcode = 8'h00, imm8 = 8'h00, mem_rdata, reg_select;
    logic [15:0] imm16 = 16'h0000, accumulator_pair = 16'h0000, index_pair = 16'h0000;
    logic [15:0] base_pair = 16'h0000, instruction_pointer, stack_pointer, mem_addr, exp_ip;
    logic [7:0] offs [3] = '{8'h7f, 8'h80, 8'h00};
    int miscompares = 0;
    int num_checks = 0;
    cag_addr_gen cag_addr_gen_i (.clk(clk), .rst(rst), .step(step), .fetch_len(fetch_len),
        .branch_kind(branch_kind), .cond_true(cond_true), .relative_offset(relative_offset),
        .imm16(imm16), .opcode(opcode), .accumulator_pair(accumulator_pair),
        .index_pair(index_pair), .base_pair(base_pair), .op_mode(op_mode), .imm8(imm8),
        .op_wide(op_wide), .op_write(op_write), .use_index(use_index), .reg_field(3'(opcode)),
        .conv_10bit(conv_10bit), .mem_rdata(mem_rdata), .instruction_pointer(instruction_pointer),
        .stack_pointer(stack_pointer), .mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we),
        .mem_wide(mem_wide), .access_fault(access_fault), .periph_drop(periph_drop),
        .reg_select(reg_select), .table_busy(table_busy));
    cag_mem_model cag_mem_model_i (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // clock source
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one-cycle request, outputs settled on return
    task automatic go();
        @(negedge clk);
        step = 1'b1;
        @(negedge clk);
        step = 1'b0;
    endtask
    task automatic op_case(input cag_mode_t m, input logic [15:0] a16, input logic [7:0] a8,
        input logic w, input logic cv, input logic [15:0] ea, input logic f);
        branch_kind = CAG_BR_NONE;
        op_mode = m;
        imm16 = a16;
        imm8 = a8;
        op_wide = w;
        conv_10bit = cv;
        go();
        exp_ip = exp_ip + 16'(fetch_len);
        check("ip op", instruction_pointer, exp_ip);
        check("fault", {mem_req, access_fault}, {~f, f});
        if (!f) begin
            check("mem_we", mem_we, op_write);
            check("mem_addr", mem_addr, ea);
            check("mem_wide", mem_wide, w);
        end
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_branches();
        for (int i = 1; i < 4; i++) begin
            fetch_len = 2'(i);
            go();
            exp_ip = exp_ip + 16'(i);
            check("ip seq", instruction_pointer, exp_ip);
        end
        for (int i = 0; i < 5; i++) begin
            branch_kind = (i < 3) ? CAG_BR_REL : CAG_BR_COND;
            relative_offset = offs[i % 3];
            cond_true = (i == 4);
            go();
            exp_ip = exp_ip + 16'h3 + ((i == 3) ? 16'h0 : {{8{relative_offset[7]}}, relative_offset});
            check("ip rel", instruction_pointer, exp_ip);
        end
        branch_kind = CAG_BR_ABS;
        imm16 = 16'hbeef;
        go();
        check("ip abs", instruction_pointer, 16'hbeef);
        branch_kind = CAG_BR_REG;
        accumulator_pair = 16'h1234;
        go();
        exp_ip = 16'h1234;
        check("ip reg", instruction_pointer, exp_ip);
    endtask
    task automatic t_table(input logic [7:0] opc);
        logic [7:0] a;
        int n;
        a = 8'h40 + {opc[5:1], 1'b0};
        branch_kind = CAG_BR_TABLE;
        opcode = opc;
        go();
        branch_kind = CAG_BR_NONE;
        check("table addr", mem_addr, {8'h00, a});
        for (n = 0; n < 8 && table_busy !== 1'b0; n++) @(negedge clk);
        if (n == 8) begin
            miscompares++;
            summarize();
        end
        exp_ip = {(a + 8'h1) ^ 8'ha5, a ^ 8'ha5};
        check("ip table", instruction_pointer, exp_ip);
    endtask
    // reset in the middle of a table call clears busy and returns the pointers to 0000 and FEFF
    task automatic t_reset();
        op_mode = CAG_OP_NONE;
        branch_kind = CAG_BR_TABLE;
        opcode = 8'h02;
        go();
        branch_kind = CAG_BR_NONE;
        check("busy call", table_busy, 1'b1);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        check("ip rst", instruction_pointer, 16'h0000);
        check("sp rst", stack_pointer, 16'hfeff);
        check("busy rst", table_busy, 1'b0);
        check("req rst", mem_req, 1'b0);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        exp_ip = 16'h0000;
        check("ip reset", instruction_pointer, 16'h0000);
        check("sp reset", stack_pointer, 16'hfeff);
        t_branches();
        t_table(8'h00);
        t_table(8'h3f);
        fetch_len = 2'h1;
        op_case(CAG_OP_DIRECT, 16'hfe00, 8'h00, 0, 0, 16'hfe00, 0);
        op_case(CAG_OP_DIRECT, 16'hff10, 8'h00, 0, 0, 16'hff10, 0);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h10, 0, 0, 16'hff10, 1);
        check("no drop", periph_drop, 1'b0);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h20, 0, 0, 16'hff20, 0);
        op_case(CAG_OP_SHORT, 16'h0000, 8'h16, 1, 0, 16'hff16, 0);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h16, 1, 0, 16'hff16, 1);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h15, 0, 0, 16'hff15, 0);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h15, 0, 1, 16'hff15, 1);
        op_case(CAG_OP_SHORT, 16'h0000, 8'h14, 1, 1, 16'hff14, 0);
        index_pair = 16'h1357;
        base_pair = 16'hfff0;
        use_index = 1'b1;
        op_case(CAG_OP_INDIRECT, 16'h0000, 8'h00, 0, 0, 16'h1357, 0);
        use_index = 1'b0;
        op_case(CAG_OP_INDIRECT, 16'h0000, 8'h00, 0, 0, 16'hfff0, 0);
        op_case(CAG_OP_BASED, 16'h0000, 8'h20, 0, 0, 16'h0010, 0);
        op_write = 1'b1;
        op_case(CAG_OP_PUSH, 16'h0000, 8'h00, 1, 0, 16'hfefd, 0);
        check("sp push", stack_pointer, 16'hfefd);
        op_case(CAG_OP_PERIPH, 16'h0000, 8'h10, 0, 0, 16'hff10, 1);
        check("drop", periph_drop, 1'b1);
        op_write = 1'b0;
        op_case(CAG_OP_POP, 16'h0000, 8'h00, 1, 0, 16'hfefd, 0);
        check("sp pop", stack_pointer, 16'hfeff);
        t_reset();
        op_mode = CAG_OP_NONE;
        for (int r = 0; r < 8; r++) begin
            opcode = 8'(r);
            go();
            check("reg_select", reg_select, 16'(8'h01 << r));
        end
        summarize();
    end
endmodule // test_cpu_address_generation
